// ---- core/power_mode_control.sv ----
`include "power_mode_control_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module power_mode_control
   import power_mode_control_pkg::*;
#(
   parameter int PORTS       = 7,
   parameter int PHY_PORTS   = 5,
   parameter int CNT_W       = 24,
   parameter int GAP_CYC     = `PMC_REFRESH_GAP_CYC,
   parameter int REFRESH_CYC = `PMC_REFRESH_LEN_CYC
) (
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   // Host mode field, written value and strobe
   input  wire logic [1:0]           mode_wr_data,
   input  wire logic                 mode_wr,
   // Per-port power down requests, one bit a port
   input  wire logic [PORTS-1:0]     port_down_req,
   // Programmed durations, counted in reference cycles
   input  wire logic [CNT_W-1:0]     idle_timeout,
   input  wire logic [CNT_W-1:0]     wake_energy_len,
   // Cable state and wake event sources
   input  wire logic                 cable_energy,
   input  wire logic                 link_up,
   input  wire logic                 wake_packet,
   input  wire logic                 wake_enable,
   input  wire logic                 event_clear,
   // Configuration straps, caught when soft down ends
   input  wire logic [7:0]           strap_in,
   // Per-port low-power idle controls
   input  wire logic [PORTS-1:0]     lpi_enable,
   input  wire logic [PORTS-1:0]     lpi_negotiated,
   input  wire logic [PORTS-1:0]     mac_tx_lpi_req,
   input  wire logic [PORTS-1:0]     rx_refresh_code,
   input  wire logic [PORTS-1:0]     rx_other_code,
   // Global mode and block enables
   output logic [1:0]                mode_status,
   output logic                      pll_clk_en,
   output logic                      phy_en,
   output logic                      mac_en,
   output logic                      mgmt_en,
   output logic                      energy_detect_only,
   // Sparse link pulses and reload strobe
   output logic                      link_pulse,
   output logic                      cfg_reload,
   output logic [7:0]                strap_cfg,
   // Per-port power and idle state
   output logic [PORTS-1:0]          port_power_en,
   output logic [PORTS-1:0]          tx_lpi,
   output logic [PORTS-1:0]          tx_refresh,
   output logic [PORTS-1:0]          rx_lpi_ind,
   output logic [PORTS-1:0]          rx_clk_stop,
   // Wake event, active low and sticky
   output logic                      power_event_out_n
);

   // ****************************************
   // State record
   // ****************************************
   // Every register of the block lives here, so one
   // always_comb builds the next copy and one always_ff
   // takes it. The enables are kept as flops of their
   // own so that every output leaves a register and no
   // decode glitch reaches the clock gates.
   typedef struct packed {
      logic [1:0]              mode;
      sleep_state_type         sleep;
      logic [CNT_W-1:0]        free_cnt;     // Free-running reference count
      logic [CNT_W-1:0]        mark;         // Count at last energy change
      logic                    energy_d;
      logic [CNT_W-1:0]        gap_cnt;      // Link pulse spacing
      logic                    cfg_reload;
      logic [7:0]              strap_cfg;
      logic [PORTS-1:0]        port_power_en;
      logic [PORTS-1:0]        tx_lpi;
      logic [PORTS-1:0]        tx_refresh;
      logic [PORTS*CNT_W-1:0]  tx_cnt;       // Per-port refresh timer
      logic [PORTS-1:0]        rx_lpi;
      logic [PORTS*4-1:0]      rx_cnt;       // Per-port idle clock count
      logic [PORTS-1:0]        rx_clk_stop;
      logic                    link_d;
      logic                    event_n;      // Wake event, active low
      logic                    link_pulse;   // One-cycle link pulse
      logic                    run_en;       // Clocks, PHYs and MACs running
      logic                    low_en;       // Only energy detect alive
      logic                    mgmt_en;      // Management kept alive
   } state_type;

   state_type state_ff;
   state_type nxt_state;

   logic [CNT_W-1:0] since_mark;  // Cycles since energy last changed
   assign since_mark = state_ff.free_cnt - state_ff.mark;

   // ****************************************
   // Per-port low-power idle
   // ****************************************
   logic [PORTS-1:0]        tx_lpi_n, tx_ref_n, rx_lpi_n, rx_stop_n;
   logic [PORTS*CNT_W-1:0]  tx_cnt_n;
   logic [PORTS*4-1:0]      rx_cnt_n;

   // Each port runs its own transmit timer and receive
   // counter; the two directions never share state, so
   // one may idle while the other carries frames.
   // Ports at or above PHY_PORTS are external MAC ports
   // and are held out of idle for good.
   genvar p;
   generate
      for (p = 0; p < PORTS; p++) begin : g_port
         logic            lpi_ok;
         logic [CNT_W-1:0] tc;
         logic [3:0]      rc;
         // Idle only on PHY ports, enabled and negotiated
         assign lpi_ok = (p < PHY_PORTS) && lpi_enable[p] && lpi_negotiated[p]
                         && state_ff.port_power_en[p] && (state_ff.mode == `PMC_MODE_NORMAL); // see (R13) see (R14)
         assign tc = state_ff.tx_cnt[p*CNT_W +: CNT_W];
         assign rc = state_ff.rx_cnt[p*4 +: 4];
         // Transmit side follows MAC request directly
         always_comb begin
            tx_lpi_n[p] = lpi_ok && mac_tx_lpi_req[p];  // see (R15) see (R16) see (R21)
            tx_ref_n[p] = 1'b0;
            tx_cnt_n[p*CNT_W +: CNT_W] = '0;
            if (tx_lpi_n[p] && state_ff.tx_lpi[p]) begin
               // Quiet then refresh burst, repeating
               if (tc == CNT_W'(GAP_CYC + REFRESH_CYC - 1)) begin
                  tx_cnt_n[p*CNT_W +: CNT_W] = '0;
               end else begin
                  tx_cnt_n[p*CNT_W +: CNT_W] = tc + 1'b1;
               end
               tx_ref_n[p] = (tc >= CNT_W'(GAP_CYC));  // see (R17)
            end
         end
         // Receive side driven by incoming code; a
         // non-refresh pattern wins over a refresh code
         // in the same cycle so frames are never lost
         always_comb begin
            rx_lpi_n[p] = state_ff.rx_lpi[p];
            if (!lpi_ok || rx_other_code[p]) begin
               rx_lpi_n[p] = 1'b0;  // see (R19)
            end else if (rx_refresh_code[p]) begin
               rx_lpi_n[p] = 1'b1;  // see (R18)
            end
            rx_cnt_n[p*4 +: 4] = 4'h0;
            if (rx_lpi_n[p] && state_ff.rx_lpi[p]) begin
               rx_cnt_n[p*4 +: 4] = (rc == 4'(`PMC_RX_STOP_CLOCKS)) ? rc : rc + 4'h1;
            end
            rx_stop_n[p] = rx_lpi_n[p] && (rx_cnt_n[p*4 +: 4] >= 4'(`PMC_RX_STOP_CLOCKS)); // see (R20)
         end
      end
   endgenerate

   // ****************************************
   // Global mode and wake logic
   // ****************************************
   always_comb begin
      nxt_state            = state_ff;
      nxt_state.free_cnt   = state_ff.free_cnt + 1'b1;  // see (R23)
      nxt_state.energy_d   = cable_energy;
      nxt_state.link_d     = link_up;
      nxt_state.cfg_reload = 1'b0;
      nxt_state.link_pulse = 1'b0;
      // Restart the duration mark on each energy change
      if (cable_energy != state_ff.energy_d) begin
         nxt_state.mark = state_ff.free_cnt;
      end
      // Mode write; a single field keeps modes exclusive
      if (mode_wr && (mode_wr_data != 2'h3)) begin
         nxt_state.mode  = mode_wr_data;  // see (R1) see (R2) see (R4) see (R5)
         nxt_state.sleep = sleep_awake;
         if (state_ff.mode == `PMC_MODE_SOFT_DOWN && mode_wr_data != `PMC_MODE_SOFT_DOWN) begin
            // Exit reloads defaults and straps
            nxt_state.cfg_reload    = 1'b1;  // see (R11)
            nxt_state.strap_cfg     = strap_in;
            nxt_state.port_power_en = '1;
            nxt_state.mode          = `PMC_MODE_NORMAL;
            nxt_state.event_n       = 1'b1;
         end
      end else if (state_ff.mode == `PMC_MODE_SLEEP) begin
         case (state_ff.sleep)
            sleep_awake: begin
               // Quiet cable past timeout
               if (!state_ff.energy_d && (since_mark > idle_timeout)) begin
                  nxt_state.sleep   = sleep_low;  // see (R7)
                  nxt_state.gap_cnt = '0;
               end
            end
            sleep_low: begin
               // Sparse link pulses while watching energy
               nxt_state.gap_cnt = state_ff.gap_cnt + 1'b1;
               if (state_ff.gap_cnt == CNT_W'(GAP_CYC)) begin
                  nxt_state.gap_cnt    = '0;
                  nxt_state.link_pulse = 1'b1;  // see (R8)
               end
               if (state_ff.energy_d && cable_energy
                   && (since_mark >= CNT_W'(`PMC_ENERGY_CYC - 1))) begin
                  nxt_state.sleep = sleep_awake;  // see (R9)
               end
            end
            default: nxt_state.sleep = sleep_awake;
         endcase
      end
      // Port power down in any mode but soft down
      if (state_ff.mode != `PMC_MODE_SOFT_DOWN) begin
         nxt_state.port_power_en = ~port_down_req;  // see (R12)
      end
      // Wake events; set wins over clear
      if (event_clear) begin
         nxt_state.event_n = 1'b1;
      end
      if (wake_enable && ((state_ff.energy_d && since_mark > wake_energy_len)
          || (link_up && !state_ff.link_d) || wake_packet)) begin
         nxt_state.event_n = 1'b0;  // see (R22)
      end
      // Output enables follow the next mode, so each
      // one leaves a flop in step with mode_status
      nxt_state.run_en  = (nxt_state.mode == `PMC_MODE_NORMAL)
                          || (nxt_state.mode == `PMC_MODE_SLEEP && nxt_state.sleep == sleep_awake);
      nxt_state.low_en  = (nxt_state.mode == `PMC_MODE_SLEEP) && (nxt_state.sleep == sleep_low);
      nxt_state.mgmt_en = 1'b1;  // see (R10)
      // Per-port idle results gathered from the loop
      nxt_state.tx_lpi      = tx_lpi_n;
      nxt_state.tx_refresh  = tx_ref_n;
      nxt_state.tx_cnt      = tx_cnt_n;
      nxt_state.rx_lpi      = rx_lpi_n;
      nxt_state.rx_cnt      = rx_cnt_n;
      nxt_state.rx_clk_stop = rx_stop_n;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         nxt_state_reset();
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Reset values; normal mode, idle off
   task automatic nxt_state_reset();
      state_ff               <= '0;
      state_ff.mode          <= `PMC_MODE_NORMAL;  // see (R2) see (R14)
      state_ff.sleep         <= sleep_awake;
      state_ff.strap_cfg     <= `PMC_RESET_CFG;
      state_ff.port_power_en <= '1;
      state_ff.event_n       <= 1'b1;
      state_ff.run_en        <= 1'b1;  // see (R3)
      state_ff.mgmt_en       <= 1'b1;
   endtask

   // ****************************************
   // Outputs, all from state flops
   // ****************************************
   // Mode and enables; all run together in normal
   // mode and in the awake half of sleep mode
   assign mode_status        = state_ff.mode;
   assign pll_clk_en         = state_ff.run_en;   // see (R3)
   assign phy_en             = state_ff.run_en;   // see (R3) see (R10)
   assign mac_en             = state_ff.run_en;
   assign mgmt_en            = state_ff.mgmt_en;  // see (R10)
   assign energy_detect_only = state_ff.low_en;   // see (R8)
   // Pulses and captured straps
   assign link_pulse         = state_ff.link_pulse;
   assign cfg_reload         = state_ff.cfg_reload;
   assign strap_cfg          = state_ff.strap_cfg;
   // Per-port state straight from the record
   assign port_power_en      = state_ff.port_power_en;
   assign tx_lpi             = state_ff.tx_lpi;
   assign tx_refresh         = state_ff.tx_refresh;
   assign rx_lpi_ind         = state_ff.rx_lpi;
   assign rx_clk_stop        = state_ff.rx_clk_stop;
   assign power_event_out_n  = state_ff.event_n;

endmodule

`default_nettype wire

// ---- core/power_mode_control_cfg.svh ----
// Notes on behaviour
// (R1) Only one global power mode at once
// (R2) Normal at reset and for field 00
// (R3) Normal mode: clocks, PHYs, MACs, management on
// (R4) Host may move from normal to any mode
// (R5) Field 01 selects cable energy sleep mode
// (R6) Host keeps auto-negotiation on in sleep mode
// (R7) No energy past timeout enters low power
// (R8) Low power: only energy detect, sparse pulses
// (R9) Energy over 100ns returns to normal power
// (R10) Soft power down keeps only management alive
// (R11) Leaving soft down reloads defaults and straps
// (R12) Each port powers down independently
// (R13) Low-power idle only on PHY ports
// (R14) Idle off at reset; needs enable and negotiation
// (R15) Transmit and receive idle controlled independently
// (R16) Transmit idle held exactly while MAC requests
// (R17) Refresh every 20-22ms lasting 200-220us
// (R18) Refresh code enters receive idle, tells MAC
// (R19) Other pattern returns MAC to normal reception
// (R20) Receive clock stops after nine idle cycles
// (R21) Wake from idle within 30us
// (R22) Wake events drive active-low power event output
// (R23) Timeouts programmable, compared against free counter
`ifndef POWER_MODE_CONTROL_CFG_SVH
`define POWER_MODE_CONTROL_CFG_SVH

// ****************************************
// Mode field encodings
// ****************************************
`define PMC_MODE_LSB          3
`define PMC_MODE_MSB          4
`define PMC_MODE_NORMAL       2'h0
`define PMC_MODE_SLEEP        2'h1
`define PMC_MODE_SOFT_DOWN    2'h2

// ****************************************
// Timing
// ****************************************
`define PMC_CLK_NS            40
`define PMC_ENERGY_MIN_NS     100
// More than 100 ns: floor(100/40)+1 cycles
`define PMC_ENERGY_CYC        ((`PMC_ENERGY_MIN_NS / `PMC_CLK_NS) + 1)
`define PMC_REFRESH_GAP_US    20000
`define PMC_REFRESH_GAP_CYC   ((`PMC_REFRESH_GAP_US * 1000) / `PMC_CLK_NS)
`define PMC_REFRESH_LEN_US    200
`define PMC_REFRESH_LEN_CYC   ((`PMC_REFRESH_LEN_US * 1000) / `PMC_CLK_NS)
`define PMC_RX_STOP_CLOCKS    9
`define PMC_WAKE_MAX_US       30
`define PMC_WAKE_MAX_CYC      ((`PMC_WAKE_MAX_US * 1000) / `PMC_CLK_NS)
`define PMC_RESET_CFG         8'h00

`endif

// ---- core/power_mode_control_pkg.sv ----
package power_mode_control_pkg;
   // Energy sleep sub-state
   typedef enum logic [0:0] {
      sleep_awake,
      sleep_low
   } sleep_state_type;
endpackage

// ---- tb/link_partner_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Cable link partner
// ****************************************
module link_partner_model #(parameter int PORTS = 7) (
   input  wire logic             clk_sys,
   input  wire logic             energy_req,
   input  wire logic             link_req,
   input  wire logic             refresh_req,
   input  wire logic             other_req,
   output var logic              cable_energy,
   output var logic              link_up,
   output var logic [PORTS-1:0]  lpi_negotiated,
   output var logic [PORTS-1:0]  rx_refresh_code,
   output var logic [PORTS-1:0]  rx_other_code
);
   initial {cable_energy, link_up, lpi_negotiated, rx_refresh_code, rx_other_code} = '0;
   // Line states move just after each edge
   always @(posedge clk_sys) begin
      cable_energy <= #1 energy_req;
      link_up <= #1 link_req;
      lpi_negotiated <= #1 '1; // Auto-negotiation kept on, both ends offer idle
      rx_refresh_code <= #1 PORTS'(refresh_req);
      rx_other_code <= #1 PORTS'(other_req);
   end
endmodule
`default_nettype wire

// ---- tb/power_mode_control_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checker of the power mode block
// ****************************************
module power_mode_control_checker #(parameter int PORTS = 7, parameter int PHY_PORTS = 5) (
   input wire logic             clk_sys,
   input wire logic             sys_rst,
   input wire logic [1:0]       mode_wr_data,
   input wire logic             mode_wr,
   input wire logic [7:0]       strap_in,
   input wire logic             cable_energy,
   input wire logic             wake_enable,
   input wire logic             wake_packet,
   input wire logic [1:0]       mode_status,
   input wire logic             pll_clk_en,
   input wire logic             phy_en,
   input wire logic             mac_en,
   input wire logic             mgmt_en,
   input wire logic             energy_detect_only,
   input wire logic             cfg_reload,
   input wire logic [7:0]       strap_cfg,
   input wire logic [PORTS-1:0] tx_lpi,
   input wire logic [PORTS-1:0] rx_lpi_ind,
   input wire logic [PORTS-1:0] rx_clk_stop,
   input wire logic             power_event_out_n
);
   // One clock domain, reset masks every check
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   property p_one_mode; mode_status != 2'h3; endproperty
   a_one_mode: assert property (p_one_mode) else $error("illegal mode code");
   property p_write; mode_wr && mode_wr_data != 2'h3 && mode_status == 2'h0
      |=> mode_status == $past(mode_wr_data); endproperty
   a_write: assert property (p_write) else $error("mode write not taken");
   property p_normal; mode_status == 2'h0 |-> pll_clk_en && phy_en && mac_en && mgmt_en && !energy_detect_only; endproperty
   a_normal: assert property (p_normal) else $error("normal mode enables wrong");
   property p_soft; mode_status == 2'h2 |-> !pll_clk_en && !phy_en && !mac_en && mgmt_en; endproperty
   a_soft: assert property (p_soft) else $error("soft down enables wrong");
   property p_leave; mode_status == 2'h2 && mode_wr && mode_wr_data == 2'h0
      |=> cfg_reload && mode_status == 2'h0 && strap_cfg == $past(strap_in); endproperty
   a_leave: assert property (p_leave) else $error("soft down exit without reload");
   property p_mac_ports; ((tx_lpi | rx_lpi_ind) >> PHY_PORTS) == '0; endproperty
   a_mac_ports: assert property (p_mac_ports) else $error("idle on a mac port");
   property p_rx_stop; rx_clk_stop[0] |-> rx_lpi_ind[0] && $past(rx_lpi_ind[0], 8); endproperty
   a_rx_stop: assert property (p_rx_stop) else $error("receive clock stopped early");
   property p_wake; wake_enable && wake_packet |=> !power_event_out_n; endproperty
   a_wake: assert property (p_wake) else $error("wake packet not flagged");
   property p_energy; (energy_detect_only && cable_energy) [*3] |-> ##[1:2] !energy_detect_only; endproperty
   a_energy: assert property (p_energy) else $error("no return on energy");
endmodule
bind power_mode_control power_mode_control_checker #(.PORTS(PORTS), .PHY_PORTS(PHY_PORTS)) chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int GAP = 50;
   localparam int REFR = 5;
   localparam logic [6:0] PHY_MASK = 7'h1f;
   localparam logic [1:0] MODES [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
   logic clk_sys = 1'b0, sys_rst = 1'b1, mode_wr = 1'b0, wake_packet = 1'b0, wake_enable = 1'b1, event_clear = 1'b0;
   logic energy_req = 1'b0, link_req = 1'b0, refresh_req = 1'b0, other_req = 1'b0;
   logic [1:0] mode_wr_data = 2'h0, seen_mode = 2'h0, mode_status;
   logic [7:0] strap_in = 8'h00, strap_v, strap_cfg;
   logic [23:0] idle_timeout = 24'h00_0014, wake_energy_len = 24'h00_000a;
   logic [6:0] port_down_req = '0, lpi_enable = '0, mac_tx_lpi_req = '0, lpi_negotiated, rx_refresh_code, rx_other_code;
   logic [6:0] port_power_en, tx_lpi, tx_refresh, rx_lpi_ind, rx_clk_stop;
   logic cable_energy, link_up, pll_clk_en, phy_en, mac_en, mgmt_en, energy_detect_only, link_pulse, cfg_reload;
   logic power_event_out_n;
   logic [1:0] exp_q[$];
   int mismatches = 0, tests_run = 0, n, seed;
   power_mode_control #(.GAP_CYC(GAP), .REFRESH_CYC(REFR)) uut (.*);
   link_partner_model #(.PORTS(7)) partner (.*);
   initial forever #20 clk_sys = ~clk_sys;
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // Bounded wait ended: a miss closes the run
   task automatic wait_done(input string what, input logic ok);
      chk(what, 8'h01, {7'h00, ok});
      if (ok !== 1'b1) stop_test();
   endtask
   // Write strobe held high, caller lowers it
   task automatic write_mode(input logic [1:0] v);
      mode_wr_data = v;
      mode_wr = 1'b1;
      if (v != 2'h3) exp_q.push_back(v);
      step(1);
   endtask
   // Mode watcher takes the oldest note on each change
   always @(posedge clk_sys) begin
      #2;
      if (!sys_rst && mode_status !== seen_mode) begin
         seen_mode = mode_status;
         chk("mode", {6'h00, exp_q.size() > 0 ? exp_q.pop_front() : 2'h3}, {6'h00, mode_status});
      end
   end
   initial begin
      #4000000;
      mismatches++;
      stop_test();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = $urandom(32'h1638_d97b);
      step(16);
      sys_rst = 1'b0;
      chk("reset mode", 8'h00, {6'h00, mode_status});
      chk("reset flags", 8'h3d, {2'b0, pll_clk_en, phy_en, mac_en, mgmt_en, energy_detect_only, power_event_out_n});
      chk("reset idle", 8'h00, {1'b0, tx_lpi | rx_lpi_ind});
      foreach (MODES[i]) write_mode(MODES[i]);
      mode_wr = 1'b0;
      step(1);
      chk("soft down", 8'h01, {4'h0, pll_clk_en, phy_en, mac_en, mgmt_en});
      strap_in = 8'($urandom);
      strap_v = strap_in;
      write_mode(2'h0);
      mode_wr = 1'b0;
      chk("reload", 8'h01, {7'h00, cfg_reload});
      chk("straps", strap_v, strap_cfg);
      write_mode(2'h1);
      mode_wr = 1'b0;
      port_down_req = 7'($urandom);
      step(2);
      chk("sleep ports", {1'b0, ~port_down_req}, {1'b0, port_power_en});
      port_down_req = '0;
      for (n = 0; n < 40 && energy_detect_only !== 1'b1; n++) step(1);
      wait_done("sleep entry", energy_detect_only);
      for (n = 0; n < GAP + 4 && link_pulse !== 1'b1; n++) step(1);
      wait_done("link pulse", link_pulse);
      energy_req = 1'b1;
      step(2);
      energy_req = 1'b0;
      step(3);
      chk("short energy", 8'h01, {7'h00, energy_detect_only});
      energy_req = 1'b1;
      for (n = 0; n < 6 && energy_detect_only !== 1'b0; n++) step(1);
      wait_done("energy return", !energy_detect_only);
      for (int k = 0; k < 3; k++) begin
         {energy_req, link_req, wake_packet, event_clear} = 4'h1;
         // Clear outlasts the lagging energy seen by the block
         step(3);
         event_clear = 1'b0;
         step(1);
         chk("event idle", 8'h01, {7'h00, power_event_out_n});
         {energy_req, link_req, wake_packet} = 3'h4 >> k;
         step(k == 0 ? 14 : 3);
         chk("event raised", 8'h00, {7'h00, power_event_out_n});
      end
      {energy_req, link_req, wake_packet} = 3'h0;
      write_mode(2'h0);
      mode_wr = 1'b0;
      for (int r = 0; r < 6; r++) begin
         mac_tx_lpi_req = 7'($urandom);
         lpi_enable = 7'($urandom);
         port_down_req = 7'($urandom);
         step(3);
         chk("tx idle", {1'b0, mac_tx_lpi_req & lpi_enable & ~port_down_req & PHY_MASK}, {1'b0, tx_lpi});
         chk("port power", {1'b0, ~port_down_req}, {1'b0, port_power_en});
      end
      // Drop every request first so the refresh timer starts from zero
      {lpi_enable, port_down_req, mac_tx_lpi_req} = {7'h7f, 7'h00, 7'h00};
      step(3);
      mac_tx_lpi_req = 7'h01;
      for (n = 0; n < GAP + REFR + 4 && tx_refresh[0] !== 1'b1; n++) step(1);
      wait_done("refresh start", tx_refresh[0]);
      for (n = 0; n < REFR + 4 && tx_refresh[0] === 1'b1; n++) step(1);
      chk("refresh length", 8'(REFR), 8'(n));
      mac_tx_lpi_req = '0;
      refresh_req = 1'b1;
      step(3);
      chk("rx idle", 8'h01, {7'h00, rx_lpi_ind[0]});
      chk("tx apart", 8'h00, {7'h00, tx_lpi[0]});
      refresh_req = 1'b0;
      step(10);
      chk("rx clock stop", 8'h01, {7'h00, rx_clk_stop[0]});
      other_req = 1'b1;
      step(3);
      chk("rx normal", 8'h00, {7'h00, rx_lpi_ind[0]});
      chk("notes left", 8'h00, 8'(exp_q.size()));
      stop_test();
   end
endmodule
`default_nettype wire
